/* core/pmcd_map.vh */
// Register offsets, field positions, reset values and timing counts for the power/clock block
`ifndef PMCD_MAP_VH
`define PMCD_MAP_VH

// Register byte offsets on the Avalon-MM slave
`define PMCD_OFF_MEMMAP 8'h00
`define PMCD_OFF_PWRCTL 8'h04
`define PMCD_OFF_PERIPH_EN 8'h08
`define PMCD_OFF_DIVCTL 8'h0C
`define PMCD_OFF_RTCSEL 8'h10
`define PMCD_OFF_PLLCTL 8'h14
`define PMCD_OFF_STATUS 8'h18

// Field positions
`define PMCD_BIT_MAP_SRAM 0
`define PMCD_BIT_IDLE 0
`define PMCD_BIT_PDOWN 1
`define PMCD_BIT_RTC_EXT 0
`define PMCD_BIT_PLL_EN 0
`define PMCD_BIT_PLL_CONN 1

// Divider ratio codes
`define PMCD_DIV_QUARTER 2'h0
`define PMCD_DIV_FULL 2'h1
`define PMCD_DIV_HALF 2'h2

// Reset values
`define PMCD_RST_MEMMAP 1'h0
`define PMCD_RST_PWRCTL 2'h0
`define PMCD_RST_PERIPH_EN 8'hFF
`define PMCD_RST_DIVCTL 2'h0
`define PMCD_RST_RTCSEL 1'h0
`define PMCD_RST_PLLCTL 2'h0

// Vector remap window and memory bases
`define PMCD_VEC_LIMIT 32'h0000_0040
`define PMCD_FLASH_BASE 32'h0000_0000
`define PMCD_SRAM_BASE 32'h4000_0000

// Oscillator settling count, in sys_clk cycles
`define PMCD_WAKE_CYCLES 16'h0800

`endif

/* core/pmcd_clk_div.v */
// Peripheral-bus clock enable divider: full, half or quarter rate
`timescale 1ns/100ps
`default_nettype none
`include "pmcd_map.vh"
module pmcd_clk_div (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire [1:0] ratio_i,
  input wire run_i,
  output reg tick_o
);
  reg [1:0] cnt_q;

  // Free counter; tick chosen from ratio so a ratio change takes effect at once
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 2'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      tick_o <= 1'b0; // No peripheral ticks while clocks are gated
    end else begin
      cnt_q <= cnt_q + 2'h1;
      case (ratio_i)
        `PMCD_DIV_FULL: tick_o <= 1'b1;
        `PMCD_DIV_HALF: tick_o <= cnt_q[0];
        default: tick_o <= (cnt_q == 2'h3); // Quarter, also reset default
      endcase
    end
  end
endmodule
`default_nettype wire

/* core/pmcd_wake_timer.v */
// Wake-up timer: holds execution until the restarted oscillator has settled
`timescale 1ns/100ps
`default_nettype none
`include "pmcd_map.vh"
module pmcd_wake_timer #(
  parameter [15:0] WAKE_CYCLES = `PMCD_WAKE_CYCLES
) (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire start_i,
  output reg busy_o
);
  reg [15:0] cnt_q;

  // Starts busy out of reset, since reset also restarts the oscillator
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 16'h0000;
      busy_o <= 1'b1;
    end else if (start_i) begin
      cnt_q <= 16'h0000;
      busy_o <= 1'b1;
    end else if (busy_o) begin
      if (cnt_q == WAKE_CYCLES - 16'h0001) begin
        busy_o <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* core/pmcd_top.v */
// Power mode, clock gating, vector remap and peripheral clock divider control
`timescale 1ns/100ps
`default_nettype none
`include "pmcd_map.vh"
module pmcd_top #(
  parameter [15:0] WAKE_CYCLES = `PMCD_WAKE_CYCLES
) (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire [31:0] fetch_addr_i,
  output reg [31:0] mapped_addr_o,
  input wire periph_irq_i,
  input wire ext_wake_i,
  input wire pll_lock_i,
  output reg cpu_clk_en_o,
  output reg bus_clk_en_o,
  output reg osc_en_o,
  output reg pll_en_o,
  output reg cpu_clk_from_pll_o,
  output reg [7:0] periph_clk_en_o,
  output reg rtc_clk_ext_o,
  output reg rtc_clk_en_o,
  output reg pin_hold_o,
  output reg retain_o
);
  // Power states
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_PDOWN = 2'h2;
  localparam [1:0] ST_WAKE = 2'h3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg map_sram_q;
  reg [1:0] pwrctl_q;
  reg [7:0] periph_en_q;
  reg [1:0] divctl_q;
  reg rtc_ext_q;
  reg [1:0] pllctl_q;
  reg ext_wake_meta_q;
  reg ext_wake_q;
  reg lock_meta_q;
  reg lock_q;
  reg [31:0] rd_val;
  wire wr_take;
  wire pclk_tick;
  wire wake_busy;
  wire wake_start;
  wire in_pdown;
  wire leave_low_power;

  // Pin-side inputs pass two flops before use
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_wake_meta_q <= 1'b0;
      ext_wake_q <= 1'b0;
      lock_meta_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      ext_wake_meta_q <= ext_wake_i;
      ext_wake_q <= ext_wake_meta_q;
      lock_meta_q <= pll_lock_i;
      lock_q <= lock_meta_q;
    end
  end

  // Bus write lands only at the edge that sees waitrequest low
  assign wr_take = avs_write_i & ~avs_waitrequest_o;

  assign in_pdown = (state_q == ST_PDOWN);
  assign wake_start = (state_q == ST_PDOWN) && ext_wake_q;
  assign leave_low_power = (state_q == ST_IDLE && (periph_irq_i || ext_wake_q)) ||
                           (state_q == ST_WAKE && !wake_busy);

  // Power state sequencing
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (pwrctl_q[`PMCD_BIT_PDOWN]) begin
          state_d = ST_PDOWN;
        end else if (pwrctl_q[`PMCD_BIT_IDLE]) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (periph_irq_i || ext_wake_q) begin
          state_d = ST_RUN;
        end
      end
      ST_PDOWN: begin
        // Only a clockless source is trusted here; peripherals are frozen
        if (ext_wake_q) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!wake_busy) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_WAKE;
    endcase
  end

  // Reset enters through the wake-up timer as well
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_WAKE;
    end else begin
      state_q <= state_d;
    end
  end

  // Software-writable registers
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      map_sram_q <= `PMCD_RST_MEMMAP;
      pwrctl_q <= `PMCD_RST_PWRCTL;
      periph_en_q <= `PMCD_RST_PERIPH_EN;
      divctl_q <= `PMCD_RST_DIVCTL;
      rtc_ext_q <= `PMCD_RST_RTCSEL;
      pllctl_q <= `PMCD_RST_PLLCTL;
    end else begin
      // Wake clears the mode request so the core does not fall back asleep
      if (leave_low_power) begin
        pwrctl_q <= 2'h0;
      end else if (wr_take && avs_address_i == `PMCD_OFF_PWRCTL) begin
        pwrctl_q <= avs_writedata_i[1:0];
      end
      if (wr_take) begin
        case (avs_address_i)
          `PMCD_OFF_MEMMAP: map_sram_q <= avs_writedata_i[`PMCD_BIT_MAP_SRAM];
          `PMCD_OFF_PERIPH_EN: periph_en_q <= avs_writedata_i[7:0];
          `PMCD_OFF_DIVCTL: divctl_q <= avs_writedata_i[1:0];
          `PMCD_OFF_RTCSEL: rtc_ext_q <= avs_writedata_i[`PMCD_BIT_RTC_EXT];
          `PMCD_OFF_PLLCTL: pllctl_q <= avs_writedata_i[1:0];
          default: ;
        endcase
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    rd_val = 32'h0000_0000;
    case (avs_address_i)
      `PMCD_OFF_MEMMAP: rd_val[0] = map_sram_q;
      `PMCD_OFF_PWRCTL: rd_val[1:0] = pwrctl_q;
      `PMCD_OFF_PERIPH_EN: rd_val[7:0] = periph_en_q;
      `PMCD_OFF_DIVCTL: rd_val[1:0] = divctl_q;
      `PMCD_OFF_RTCSEL: rd_val[0] = rtc_ext_q;
      `PMCD_OFF_PLLCTL: rd_val[1:0] = pllctl_q;
      `PMCD_OFF_STATUS: rd_val[4:0] = {cpu_clk_from_pll_o, lock_q, wake_busy, state_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // One wait cycle, then a single low cycle with data standing
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o <= avs_read_i ? rd_val : 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Peripheral clock divider, stopped only by power-down
  pmcd_clk_div u_div (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .ratio_i(divctl_q),
    .run_i(~in_pdown),
    .tick_o(pclk_tick)
  );

  // Oscillator settling timer
  pmcd_wake_timer #(
    .WAKE_CYCLES(WAKE_CYCLES)
  ) u_wake (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(wake_start),
    .busy_o(wake_busy)
  );

  // Vector fetches below the limit go to flash or SRAM; a one-cycle lookup
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mapped_addr_o <= 32'h0000_0000;
    end else if (fetch_addr_i < `PMCD_VEC_LIMIT) begin
      mapped_addr_o <= (map_sram_q ? `PMCD_SRAM_BASE : `PMCD_FLASH_BASE) | fetch_addr_i;
    end else begin
      mapped_addr_o <= fetch_addr_i;
    end
  end

  // Core, bus, oscillator and PLL gating from the power state
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_clk_en_o <= 1'b0;
      bus_clk_en_o <= 1'b0;
      osc_en_o <= 1'b1;
      pll_en_o <= 1'b0;
      cpu_clk_from_pll_o <= 1'b0;
      pin_hold_o <= 1'b0;
      retain_o <= 1'b0;
    end else begin
      // Core and buses only run in the run state
      cpu_clk_en_o <= (state_d == ST_RUN);
      bus_clk_en_o <= (state_d == ST_RUN);
      osc_en_o <= (state_d != ST_PDOWN);
      // Idle leaves the PLL alone since the divider feeds from it
      pll_en_o <= pllctl_q[`PMCD_BIT_PLL_EN] && (state_d != ST_PDOWN);
      // Switch to the PLL only once it reports lock
      cpu_clk_from_pll_o <= pllctl_q[`PMCD_BIT_PLL_EN] && pllctl_q[`PMCD_BIT_PLL_CONN] &&
                            lock_q && (state_d != ST_PDOWN);
      pin_hold_o <= (state_d == ST_PDOWN);
      retain_o <= (state_d == ST_PDOWN);
    end
  end

  // Per-peripheral enables, one flop per peripheral
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pclk
      always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          periph_clk_en_o[gi] <= 1'b0;
        end else begin
          periph_clk_en_o[gi] <= pclk_tick & periph_en_q[gi] & (state_d != ST_PDOWN);
        end
      end
    end
  endgenerate

  // RTC keeps ticking in power-down only on the external low-rate clock
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rtc_clk_ext_o <= 1'b0;
      rtc_clk_en_o <= 1'b0;
    end else begin
      rtc_clk_ext_o <= rtc_ext_q;
      rtc_clk_en_o <= rtc_ext_q | (pclk_tick & (state_d != ST_PDOWN));
    end
  end
endmodule
`default_nettype wire

/* verification/pmcd_core_model.sv */
// Core and peripheral side model: fetch addresses, wake sources, PLL lock
`timescale 1ns/100ps
`default_nettype none
module pmcd_core_model (
  input wire logic clk_i,
  input wire logic pll_en_i,
  output logic [31:0] fetch_addr_o,
  output logic irq_o,
  output logic wake_o,
  output logic lock_o
);
  logic [2:0] irq_cnt = 3'h0;
  logic [2:0] wake_cnt = 3'h0;
  logic [2:0] lock_cnt = 3'h0;
  initial fetch_addr_o = 32'h0000_0000;
  // Wake sources stay up three cycles so the synchroniser always sees them
  always @(posedge clk_i) begin
    if (irq_cnt != 3'h0) irq_cnt <= irq_cnt - 3'h1;
    if (wake_cnt != 3'h0) wake_cnt <= wake_cnt - 3'h1;
  end
  assign irq_o = irq_cnt != 3'h0;
  assign wake_o = wake_cnt != 3'h0;
  // Lock comes late and is lost at once when the PLL is disabled
  always @(posedge clk_i) begin
    lock_cnt <= !pll_en_i ? 3'h0 : (lock_cnt == 3'h7 ? lock_cnt : lock_cnt + 3'h1);
  end
  assign lock_o = lock_cnt >= 3'h4;
  task fetch(input logic [31:0] a);
    @(posedge clk_i);
    fetch_addr_o <= a;
  endtask
  task pulse_irq;
    @(posedge clk_i);
    irq_cnt <= 3'h3;
  endtask
  task pulse_wake;
    @(posedge clk_i);
    wake_cnt <= 3'h3;
  endtask
endmodule
`default_nettype wire

/* verification/pmcd_properties.sv */
// Concurrent checks on the power and clock control ports
`timescale 1ns/100ps
`default_nettype none
module pmcd_properties #(
  parameter [15:0] WAKE_CYCLES = 16'h0008
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [31:0] fetch_addr_i,
  input wire logic [31:0] mapped_addr_o,
  input wire logic ext_wake_i,
  input wire logic cpu_clk_en_o,
  input wire logic bus_clk_en_o,
  input wire logic osc_en_o,
  input wire logic pll_en_o,
  input wire logic cpu_clk_from_pll_o,
  input wire logic [7:0] periph_clk_en_o,
  input wire logic rtc_clk_ext_o,
  input wire logic rtc_clk_en_o,
  input wire logic pin_hold_o,
  input wire logic retain_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // One wait state, then a single low cycle
  chk_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus request not answered");
  chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  chk_map_pass: assert property (fetch_addr_i >= 32'h0000_0040 |=>
    mapped_addr_o == $past(fetch_addr_i)) else $error("address outside vectors moved");
  chk_bus_core: assert property (bus_clk_en_o == cpu_clk_en_o)
    else $error("bus and core gating differ");
  chk_pd_stop: assert property (pin_hold_o |-> !osc_en_o && !pll_en_o && !cpu_clk_en_o
    && periph_clk_en_o == 8'h00) else $error("clock alive in power-down");
  chk_pd_retain: assert property (pin_hold_o == retain_o)
    else $error("retention and pin hold differ");
  chk_pd_stays: assert property (!ext_wake_i [*3] ##0 pin_hold_o |=> pin_hold_o)
    else $error("power-down left without wake pin");
  chk_rtc_pd: assert property (pin_hold_o |-> rtc_clk_en_o == rtc_clk_ext_o)
    else $error("rtc clock wrong in power-down");
  chk_pll_clk: assert property (cpu_clk_from_pll_o |-> pll_en_o)
    else $error("core on pll while pll off");
  chk_wake_wait: assert property ($fell(pin_hold_o) |-> !cpu_clk_en_o [*4])
    else $error("core ran before wake timer");
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the power and clock control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam [15:0] WAKE_CYCLES = 16'h0008;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] q;
  logic [7:0] m;
  wire [31:0] rdata, mapped, fetch;
  wire [7:0] pclk;
  wire waitreq, irq, wake, lock, cpu_en, bus_en, osc_en, pll_en, from_pll;
  wire rtc_ext, rtc_en, hold, retain;
  int errors = 0;
  int cmp_count = 0;
  int n;
  // Free-running clock, 50 ns period
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  pmcd_top #(.WAKE_CYCLES(WAKE_CYCLES)) DUT (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .fetch_addr_i(fetch),
    .mapped_addr_o(mapped), .periph_irq_i(irq), .ext_wake_i(wake), .pll_lock_i(lock),
    .cpu_clk_en_o(cpu_en), .bus_clk_en_o(bus_en), .osc_en_o(osc_en), .pll_en_o(pll_en),
    .cpu_clk_from_pll_o(from_pll), .periph_clk_en_o(pclk), .rtc_clk_ext_o(rtc_ext),
    .rtc_clk_en_o(rtc_en), .pin_hold_o(hold), .retain_o(retain));
  pmcd_core_model u_core (.clk_i(sys_clk), .pll_en_i(pll_en), .fetch_addr_o(fetch),
    .irq_o(irq), .wake_o(wake), .lock_o(lock));
  task report_and_stop;
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; request held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    rd <= !w; wr <= w; adr <= a; wd <= d;
    do @(posedge sys_clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Count peripheral 0 pulses and collect every enable seen
  // Skip a few cycles first: a ratio written just before takes two edges to reach the pins
  task count;
    n = 0; m = 8'h00;
    repeat (4) @(negedge sys_clk);
    repeat (16) begin
      @(negedge sys_clk);
      n += pclk[0];
      m = m | pclk;
    end
  endtask
  task wait_run;
    for (int i = 0; i < 100 && cpu_en !== 1'b1; i++) @(negedge sys_clk);
  endtask
  task t_reset;
    wait_run;
    bus(1'b0, 8'h0C, 32'h0000_0000); chk(q, 32'h0000_0000);
    count; chk(n, 4);
    bus(1'b0, 8'h1C, 32'h0000_0000); chk(q, 32'h0000_0000);
  endtask
  task t_div;
    bus(1'b1, 8'h0C, 32'h0000_0001); count; chk(n, 16);
    bus(1'b1, 8'h0C, 32'h0000_0002); count; chk(n, 8);
    bus(1'b1, 8'h0C, 32'h0000_0003); count; chk(n, 4);
    bus(1'b1, 8'h08, 32'h0000_0001); count; chk(m, 8'h01);
  endtask
  // Remap only touches the vector window
  task t_map;
    bus(1'b1, 8'h00, 32'h0000_0001);
    u_core.fetch(32'h0000_0010); repeat (2) @(negedge sys_clk); chk(mapped, 32'h4000_0010);
    u_core.fetch(32'h0000_0100); repeat (2) @(negedge sys_clk); chk(mapped, 32'h0000_0100);
    bus(1'b1, 8'h00, 32'h0000_0000);
    u_core.fetch(32'h0000_0010); repeat (2) @(negedge sys_clk); chk(mapped, 32'h0000_0010);
    bus(1'b1, 8'h00, 32'h0000_0001);
  endtask
  task t_idle;
    bus(1'b1, 8'h14, 32'h0000_0003); repeat (10) @(negedge sys_clk); chk(from_pll, 1);
    bus(1'b1, 8'h04, 32'h0000_0001); repeat (2) @(negedge sys_clk);
    chk({cpu_en, bus_en, pll_en}, 3'b001);
    count; chk(n, 4);
    u_core.pulse_irq; wait_run; chk(cpu_en, 1);
    bus(1'b0, 8'h04, 32'h0000_0000); chk(q, 32'h0000_0000);
  endtask
  // Power-down with external RTC clock, then a wake through the timer
  task t_pdown;
    bus(1'b1, 8'h10, 32'h0000_0001);
    bus(1'b1, 8'h04, 32'h0000_0002); repeat (2) @(negedge sys_clk);
    chk({osc_en, pll_en, hold, retain, rtc_ext, rtc_en, pclk}, 14'h0F00);
    u_core.pulse_irq; repeat (6) @(negedge sys_clk); chk(hold, 1);
    u_core.pulse_wake;
    for (n = 0; n < 100 && cpu_en !== 1'b1; n++) @(negedge sys_clk);
    chk(n >= WAKE_CYCLES, 1);
    chk({cpu_en, hold}, 2'b10);
    bus(1'b0, 8'h00, 32'h0000_0000); chk(q, 32'h0000_0001);
    bus(1'b0, 8'h04, 32'h0000_0000); chk(q, 32'h0000_0000);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_div;
    t_map;
    t_idle;
    t_pdown;
    report_and_stop;
  end
  // Watchdog well beyond the whole sequence
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    report_and_stop;
  end
endmodule
bind pmcd_top pmcd_properties #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.sys_clk_i, .rst_b_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .fetch_addr_i, .mapped_addr_o, .ext_wake_i,
  .cpu_clk_en_o, .bus_clk_en_o, .osc_en_o, .pll_en_o, .cpu_clk_from_pll_o, .periph_clk_en_o,
  .rtc_clk_ext_o, .rtc_clk_en_o, .pin_hold_o, .retain_o);
`default_nettype wire
